// ---- core/csc_cfg.svh ----
// Register indices, field positions and reset values of the slot control block.
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
`define CSC_IDX_PWR 8'h02
`define CSC_IDX_IGC 8'h03
`define CSC_IDX_CSC 8'h04
`define CSC_IDX_CSCCFG 8'h05
`define CSC_IDX_WEN 8'h06
`define CSC_IDX_WIDTH 8'h11
`define CSC_IDX_OFFLO 8'h14
`define CSC_IDX_OFFHI 8'h15
`define CSC_IDX_DGC 8'h16
`define CSC_IDX_GLB 8'h1e
`define CSC_IDX_VSENSE 8'h1f
`define CSC_IDX_SUPPLY_SELECT 8'h2f
`define CSC_IDX_IST 8'h40
`define CSC_IDX_IMSK 8'h41
`define CSC_IDX_LSB 2
`define CSC_IDX_MSB 9
`define CSC_RST8 8'h00
`define CSC_DGC_SOFT 5
`define CSC_DGC_RESUME 4
`define CSC_DGC_CFGRST 1
`define CSC_DGC_DLYINH 0
`define CSC_DGC_WMASK 8'h13
`define CSC_GLB_EXPL 2
`define CSC_GLB_WMASK 8'h04
`define CSC_SUPPLY_SELECT_WMASK 8'h03
`define CSC_OH_WP 7
`define CSC_OH_ATTR 6
`define CSC_OH_OFF_MSB 5
`define CSC_WID_16 7
`define CSC_PWR_EN 4
`define CSC_CSC_DET 3
`define CSC_CFG_DETEN 3
`define CSC_WEN_MW0 0
`define CSC_IST_DET 0
`define CSC_IST_RMV 1
`define CSC_IST_WMASK 8'h03
`define CSC_SUPPLY_SELECT_5V 2'b00
`define CSC_SUPPLY_SELECT_OFF 2'b10
`endif

// ---- core/csc_pkg.sv ----
// Types shared by the slot control block.
package csc_pkg;
    typedef enum logic [0:0] {
        CSC_APB_IDLE = 1'b0,
        CSC_APB_RESP = 1'b1
    } csc_apb_st_t;
    typedef logic [7:0] csc_byte_t;
    typedef logic [13:0] csc_card_addr_t;
endpackage : csc_pkg

// ---- core/csc_slot_regs.sv ----
// Slot configuration, card detect, window address and supply logic behind an APB slave.
//
// How it works
// [RQ1] A write-protected window never lets a write strobe reach the card.
// [RQ2] The attribute select bit chooses attribute memory, else common memory.
// [RQ3] Upper offset bits add to system bits 25 to 20, taking the low carry.
// [RQ4] The low offset byte adds to system bits 19 to 12 in an enabled window.
// [RQ5] Writing the soft detect bit with detect enabled raises a detect change.
// [RQ6] The soft detect bit reads zero and does nothing while detect is disabled.
// [RQ7] With detect enabled, any change on the two detect inputs raises a hardware detect change.
// [RQ8] With resume enabled a hardware change pulls resume low until the status bit clears.
// [RQ9] Resume is only produced while card detect interrupts are enabled.
// [RQ10] With resume enabled a hardware change does not drive the routed request.
// [RQ11] Host software follows a resume-signalled change with a soft detect write.
// [RQ12] Both detect inputs going high with reset enabled clears the slot setup.
// [RQ13] Sixteen-bit windows delay strobe falling edges one clock unless inhibited.
// [RQ14] Status read clears bits, or in explicit mode only a written one clears.
// [RQ15] The voltage sense register shows the two sense inputs in bits 1 and 0.
// [RQ16] With power enabled the supply select drives the two supply controls.
// [RQ17] Detect inputs are synchronised and compared with their previous sample.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"
module csc_slot_regs (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // System memory side.
    input wire logic i_mem_req,
    input wire logic [13:0] i_sys_addr,
    input wire logic i_sys_we_n,
    input wire logic i_sys_oe_n,
    // Card side.
    input wire logic i_card_detect_a_n,
    input wire logic i_card_detect_b_n,
    input wire logic i_volt_sense_a,
    input wire logic i_volt_sense_b,
    output logic [13:0] o_card_addr,
    output logic o_card_sel,
    output logic o_card_attr,
    output logic o_card_we_n,
    output logic o_card_oe_n,
    output logic o_supply_5v_ctrl,
    output logic o_supply_3v_ctrl,
    // Events.
    output logic o_resume_request_n,
    output logic o_csc_irq,
    output logic o_irq
);
    import csc_pkg::*;

    function automatic csc_card_addr_t add_offset(input csc_card_addr_t sys,
                                                  input csc_card_addr_t off);
        add_offset = csc_card_addr_t'(sys + off);
    endfunction : add_offset

    function automatic csc_byte_t wr_merge(input csc_byte_t old, input csc_byte_t wd,
                                           input csc_byte_t msk);
        wr_merge = (old & ~msk) | (wd & msk);
    endfunction : wr_merge

    ////////////////////////////////////////////////////////////////////////////////
    // APB access decode.

    csc_apb_st_t apb_st_q;
    csc_apb_st_t apb_st_d;
    logic [31:0] prdata_q;
    logic pslverr_q;
    wire [7:0] idx = i_paddr[`CSC_IDX_MSB:`CSC_IDX_LSB];
    wire access = i_psel && i_penable;
    wire fire = access && (apb_st_q == CSC_APB_RESP);
    wire wr_fire = fire && i_pwrite;
    wire rd_fire = fire && !i_pwrite;
    wire [7:0] wd = i_pwdata[7:0];
    wire wr_pwr = wr_fire && (idx == `CSC_IDX_PWR);
    wire wr_igc = wr_fire && (idx == `CSC_IDX_IGC);
    wire wr_csc = wr_fire && (idx == `CSC_IDX_CSC);
    wire wr_cscfg = wr_fire && (idx == `CSC_IDX_CSCCFG);
    wire wr_wen = wr_fire && (idx == `CSC_IDX_WEN);
    wire wr_width = wr_fire && (idx == `CSC_IDX_WIDTH);
    wire wr_offlo = wr_fire && (idx == `CSC_IDX_OFFLO);
    wire wr_offhi = wr_fire && (idx == `CSC_IDX_OFFHI);
    wire wr_dgc = wr_fire && (idx == `CSC_IDX_DGC);
    wire wr_glb = wr_fire && (idx == `CSC_IDX_GLB);
    wire wr_supply_select = wr_fire && (idx == `CSC_IDX_SUPPLY_SELECT);
    wire wr_ist = wr_fire && (idx == `CSC_IDX_IST);
    wire wr_imsk = wr_fire && (idx == `CSC_IDX_IMSK);
    wire rd_csc = rd_fire && (idx == `CSC_IDX_CSC);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    csc_byte_t pwr_q;
    csc_byte_t igc_q;
    csc_byte_t cscfg_q;
    csc_byte_t wen_q;
    csc_byte_t width_q;
    csc_byte_t offlo_q;
    csc_byte_t offhi_q;
    csc_byte_t dgc_q;
    csc_byte_t glb_q;
    csc_byte_t supply_select_q;
    csc_byte_t ist_q;
    csc_byte_t imsk_q;
    logic det_q;
    logic hw_src_q;
    logic cfg_rst_q;
    logic [1:0] cd_meta_q;
    logic [1:0] cd_sync_q;
    logic [1:0] cd_prev_q;
    logic we_prev_n_q;
    logic oe_prev_n_q;

    wire det_en = cscfg_q[`CSC_CFG_DETEN];
    wire resume_en = dgc_q[`CSC_DGC_RESUME];
    wire expl_ack = glb_q[`CSC_GLB_EXPL];
    wire hw_change = (cd_sync_q != cd_prev_q); // RQ7 RQ17
    wire hw_evt = hw_change && det_en; // RQ7
    wire sw_evt = wr_dgc && wd[`CSC_DGC_SOFT] && det_en; // RQ5 RQ6
    wire det_set = hw_evt || sw_evt;
    wire det_ack = (rd_csc && !expl_ack) || (wr_csc && expl_ack && wd[`CSC_CSC_DET]); // RQ14
    // Set wins over the acknowledge so a change in the clearing cycle is kept.
    wire det_d = det_set || (det_q && !det_ack);
    wire hw_src_q_next = hw_evt || (hw_src_q && !sw_evt && det_d);
    wire removed = (cd_sync_q == 2'b11) && (cd_prev_q != 2'b11); // RQ12
    wire cfg_rst_d = removed && dgc_q[`CSC_DGC_CFGRST]; // RQ12
    wire [7:0] ist_evt = {6'h00, cfg_rst_d, det_set};
    wire [7:0] ist_clr = wr_ist ? (wd & `CSC_IST_WMASK) : `CSC_RST8;
    wire [7:0] ist_d = ist_evt | (ist_q & ~ist_clr);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cd_meta_q <= 2'b11;
            cd_sync_q <= 2'b11;
            cd_prev_q <= 2'b11;
        end else begin
            cd_meta_q <= {i_card_detect_b_n, i_card_detect_a_n};
            cd_sync_q <= cd_meta_q; // RQ17
            cd_prev_q <= cd_sync_q; // RQ17
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwr_q <= `CSC_RST8;
            cscfg_q <= `CSC_RST8;
            dgc_q <= `CSC_RST8;
            glb_q <= `CSC_RST8;
            supply_select_q <= `CSC_RST8;
            imsk_q <= `CSC_RST8;
            ist_q <= `CSC_RST8;
            det_q <= 1'b0;
            hw_src_q <= 1'b0;
            cfg_rst_q <= 1'b0;
        end else begin
            if (wr_pwr) pwr_q <= wd;
            if (wr_cscfg) cscfg_q <= wd;
            if (wr_dgc) dgc_q <= wr_merge(dgc_q, wd, `CSC_DGC_WMASK); // RQ6
            if (wr_glb) glb_q <= wr_merge(glb_q, wd, `CSC_GLB_WMASK);
            if (wr_supply_select) supply_select_q <= wr_merge(supply_select_q, wd, `CSC_SUPPLY_SELECT_WMASK);
            if (wr_imsk) imsk_q <= wd & `CSC_IST_WMASK;
            ist_q <= ist_d;
            det_q <= det_d; // RQ5 RQ8 RQ14
            hw_src_q <= hw_src_q_next;
            cfg_rst_q <= cfg_rst_d; // RQ12
        end
    end

    // The registered removal pulse clears the window setup two cycles after the synchronised inputs first read high.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            igc_q <= `CSC_RST8;
            wen_q <= `CSC_RST8;
            width_q <= `CSC_RST8;
            offlo_q <= `CSC_RST8;
            offhi_q <= `CSC_RST8;
        end else if (cfg_rst_q) begin
            igc_q <= `CSC_RST8; // RQ12
            wen_q <= `CSC_RST8; // RQ12
            width_q <= `CSC_RST8; // RQ12
            offlo_q <= `CSC_RST8; // RQ12
            offhi_q <= `CSC_RST8; // RQ12
        end else begin
            if (wr_igc) igc_q <= wd;
            if (wr_wen) wen_q <= wd;
            if (wr_width) width_q <= wd;
            if (wr_offlo) offlo_q <= wd;
            if (wr_offhi) offhi_q <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and APB answer.

    wire [7:0] vsense = {6'h00, i_volt_sense_b, i_volt_sense_a}; // RQ15
    wire [7:0] csc_rd = {4'h0, det_q, 3'h0};
    wire [7:0] dgc_rd = dgc_q & `CSC_DGC_WMASK; // RQ6
    wire hit_map = (idx == `CSC_IDX_PWR) || (idx == `CSC_IDX_IGC) || (idx == `CSC_IDX_CSC) ||
                   (idx == `CSC_IDX_CSCCFG) || (idx == `CSC_IDX_WEN) ||
                   (idx == `CSC_IDX_WIDTH) || (idx == `CSC_IDX_OFFLO) ||
                   (idx == `CSC_IDX_OFFHI) || (idx == `CSC_IDX_DGC) ||
                   (idx == `CSC_IDX_GLB) || (idx == `CSC_IDX_VSENSE) ||
                   (idx == `CSC_IDX_SUPPLY_SELECT) || (idx == `CSC_IDX_IST) || (idx == `CSC_IDX_IMSK);
    wire unmapped = !hit_map || (i_paddr[1:0] != 2'b00) ||
                    (i_paddr[31:`CSC_IDX_MSB + 1] != 22'h000000);
    wire [7:0] rd_mux =
        unmapped ? `CSC_RST8 :
        (idx == `CSC_IDX_PWR) ? pwr_q :
        (idx == `CSC_IDX_IGC) ? igc_q :
        (idx == `CSC_IDX_CSC) ? csc_rd :
        (idx == `CSC_IDX_CSCCFG) ? cscfg_q :
        (idx == `CSC_IDX_WEN) ? wen_q :
        (idx == `CSC_IDX_WIDTH) ? width_q :
        (idx == `CSC_IDX_OFFLO) ? offlo_q :
        (idx == `CSC_IDX_OFFHI) ? offhi_q :
        (idx == `CSC_IDX_DGC) ? dgc_rd :
        (idx == `CSC_IDX_GLB) ? glb_q :
        (idx == `CSC_IDX_VSENSE) ? vsense :
        (idx == `CSC_IDX_SUPPLY_SELECT) ? supply_select_q :
        (idx == `CSC_IDX_IST) ? ist_q : imsk_q;

    always_comb begin
        case (apb_st_q)
            CSC_APB_IDLE: apb_st_d = access ? CSC_APB_RESP : CSC_APB_IDLE;
            CSC_APB_RESP: apb_st_d = CSC_APB_IDLE;
            default: apb_st_d = CSC_APB_IDLE;
        endcase
    end

    // One wait state gives registered read data and a registered error flag.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            apb_st_q <= CSC_APB_IDLE;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            apb_st_q <= apb_st_d;
            prdata_q <= (access && !i_pwrite) ? {24'h000000, rd_mux} : 32'h00000000;
            pslverr_q <= access && (apb_st_q == CSC_APB_IDLE) && unmapped;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = (apb_st_q == CSC_APB_RESP);
    assign o_pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Memory window path and card outputs.

    wire win_hit = i_mem_req && wen_q[`CSC_WEN_MW0]; // RQ4
    wire wp = offhi_q[`CSC_OH_WP];
    wire dly = width_q[`CSC_WID_16] && !dgc_q[`CSC_DGC_DLYINH]; // RQ13
    wire [13:0] off = {offhi_q[`CSC_OH_OFF_MSB:0], offlo_q};
    wire [13:0] card_addr_d = add_offset(i_sys_addr, off); // RQ3 RQ4
    // A strobe goes low only once it has been low for a cycle when the delay is on.
    wire we_low = win_hit && !i_sys_we_n && !wp && !(dly && we_prev_n_q); // RQ1 RQ13
    wire oe_low = win_hit && !i_sys_oe_n && !(dly && oe_prev_n_q); // RQ13
    wire resume_d = !(det_d && hw_src_q_next && resume_en && det_en); // RQ8 RQ9
    wire csc_irq_d = det_d && !(resume_en && hw_src_q_next); // RQ10
    logic [13:0] card_addr_q;
    logic card_sel_q;
    logic card_attr_q;
    logic card_we_n_q;
    logic card_oe_n_q;
    logic sup5_q;
    logic sup3_q;
    logic resume_n_q;
    logic csc_irq_q;
    logic irq_q;
    logic [1:0] sup_d;

    always_comb begin
        sup_d = 2'b11;
        if (pwr_q[`CSC_PWR_EN]) begin
            case (supply_select_q[1:0])
                `CSC_SUPPLY_SELECT_5V: sup_d = 2'b01; // RQ16
                `CSC_SUPPLY_SELECT_OFF: sup_d = 2'b11; // RQ16
                default: sup_d = 2'b10; // RQ16
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            card_addr_q <= 14'h0000;
            card_sel_q <= 1'b0;
            card_attr_q <= 1'b0;
            card_we_n_q <= 1'b1;
            card_oe_n_q <= 1'b1;
            we_prev_n_q <= 1'b1;
            oe_prev_n_q <= 1'b1;
            sup5_q <= 1'b1;
            sup3_q <= 1'b1;
            resume_n_q <= 1'b1;
            csc_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            card_addr_q <= card_addr_d; // RQ3 RQ4
            card_sel_q <= win_hit;
            card_attr_q <= offhi_q[`CSC_OH_ATTR]; // RQ2
            card_we_n_q <= !we_low; // RQ1
            card_oe_n_q <= !oe_low;
            we_prev_n_q <= i_sys_we_n;
            oe_prev_n_q <= i_sys_oe_n;
            sup5_q <= sup_d[1];
            sup3_q <= sup_d[0];
            resume_n_q <= resume_d; // RQ8
            csc_irq_q <= csc_irq_d; // RQ10 RQ11
            irq_q <= |(ist_d & imsk_q);
        end
    end

    assign o_card_addr = card_addr_q;
    assign o_card_sel = card_sel_q;
    assign o_card_attr = card_attr_q;
    assign o_card_we_n = card_we_n_q;
    assign o_card_oe_n = card_oe_n_q;
    assign o_supply_5v_ctrl = sup5_q;
    assign o_supply_3v_ctrl = sup3_q;
    assign o_resume_request_n = resume_n_q;
    assign o_csc_irq = csc_irq_q;
    assign o_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    property p_wp_blocks;
        win_hit && wp |=> o_card_we_n;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) else $error("Protected write reached card."); // RQ1

    property p_attr;
        1'b1 |=> o_card_attr == $past(offhi_q[`CSC_OH_ATTR]);
    endproperty
    a_attr: assert property (p_attr) else $error("Attribute select not followed."); // RQ2

    property p_addr;
        win_hit |=> o_card_addr == $past(i_sys_addr) + $past(off);
    endproperty
    a_addr: assert property (p_addr) else $error("Card address sum wrong."); // RQ3

    property p_soft;
        sw_evt && !hw_evt |=> det_q && o_csc_irq;
    endproperty
    a_soft: assert property (p_soft) else $error("Soft detect did not set status."); // RQ5

    property p_soft_off;
        wr_dgc && !det_en && !hw_evt && !det_q |=> !det_q;
    endproperty
    a_soft_off: assert property (p_soft_off) else $error("Soft detect acted while off."); // RQ6

    property p_hw;
        hw_change && det_en |=> det_q;
    endproperty
    a_hw: assert property (p_hw) else $error("Detect change lost."); // RQ7

    sequence s_resume_cause;
        hw_change && det_en && resume_en;
    endsequence
    property p_resume;
        s_resume_cause |=> !o_resume_request_n && !o_csc_irq;
    endproperty
    a_resume: assert property (p_resume) else $error("Resume not signalled."); // RQ8

    property p_resume_gate;
        !det_en |-> ##1 o_resume_request_n;
    endproperty
    a_resume_gate: assert property (p_resume_gate) else $error("Resume without enable."); // RQ9

    property p_cfg_rst;
        cfg_rst_d |=> ##1 (offlo_q == `CSC_RST8) && (wen_q == `CSC_RST8);
    endproperty
    a_cfg_rst: assert property (p_cfg_rst) else $error("Removal reset missed."); // RQ12

    property p_delay;
        dly && win_hit && $fell(i_sys_oe_n) |=> o_card_oe_n;
    endproperty
    a_delay: assert property (p_delay) else $error("Strobe not delayed."); // RQ13

    property p_ack;
        rd_csc && !expl_ack && !det_set |=> !det_q;
    endproperty
    a_ack: assert property (p_ack) else $error("Read did not acknowledge."); // RQ14

    property p_supply;
        pwr_q[`CSC_PWR_EN] && supply_select_q[1:0] == `CSC_SUPPLY_SELECT_5V |=> !o_supply_5v_ctrl && o_supply_3v_ctrl;
    endproperty
    a_supply: assert property (p_supply) else $error("Supply select wrong."); // RQ16
endmodule : csc_slot_regs
`default_nettype wire

// ---- testbench/csc_card_model.sv ----
// Behavioural model of the card in the slot: detect and voltage sense pins.
`timescale 1ns/1ps
`default_nettype none
module csc_card_model (
    // Control from the bench.
    input wire logic i_present,
    input wire logic [1:0] i_sense,
    // Slot pins.
    output logic o_card_detect_a_n,
    output logic o_card_detect_b_n,
    output logic o_volt_sense_a,
    output logic o_volt_sense_b
);
    // Both detect lines are pulled up, so an empty slot reads high on each.
    assign o_card_detect_a_n = !i_present;
    assign o_card_detect_b_n = !i_present;
    // Sense lines are pulled up too; without a card they float to that level.
    assign o_volt_sense_a = i_present ? i_sense[0] : 1'b1;
    assign o_volt_sense_b = i_present ? i_sense[1] : 1'b1;
endmodule : csc_card_model
`default_nettype wire

// ---- testbench/tb_card_slot_control_regs.sv ----
// Self-checking bench for the slot control register block.
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"
module tb_card_slot_control_regs;
    typedef struct packed {logic [1:0] code; logic [1:0] sup;} csc_row_t;
    typedef struct packed {
        logic [7:0] wid;
        logic [7:0] dgc;
        logic [7:0] ohi;
        logic e1;
        logic e2;
    } csc_wrow_t;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdata;
    logic mem_req, we_n, oe_n, det_a_n, det_b_n, vs_a, vs_b, present, rerr;
    logic [13:0] sys_addr, card_addr;
    logic [1:0] sense;
    logic card_sel, card_attr, card_we_n, card_oe_n, sup5, sup3, resume_n, csc_irq, irq;
    int bad_count = 0;
    int samples_checked = 0;
    // Supply outputs per select code, with the sense code fed back alongside.
    csc_row_t rows [4] = '{'{2'b00, 2'b01}, '{2'b01, 2'b10}, '{2'b10, 2'b11}, '{2'b11, 2'b10}};
    // Width, general control, offset high, write strobe one and two cycles on.
    csc_wrow_t wrows [4] = '{'{8'h00, 8'h00, 8'h01, 1'b0, 1'b0},
        '{8'h80, 8'h00, 8'h41, 1'b1, 1'b0}, '{8'h80, 8'h01, 8'h01, 1'b0, 1'b0},
        '{8'h00, 8'h00, 8'h81, 1'b1, 1'b1}};

    always #2.5 clk = ~clk;

    csc_slot_regs dut_u (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_mem_req(mem_req),
        .i_sys_addr(sys_addr), .i_sys_we_n(we_n), .i_sys_oe_n(oe_n),
        .i_card_detect_a_n(det_a_n), .i_card_detect_b_n(det_b_n),
        .i_volt_sense_a(vs_a), .i_volt_sense_b(vs_b), .o_card_addr(card_addr),
        .o_card_sel(card_sel), .o_card_attr(card_attr), .o_card_we_n(card_we_n),
        .o_card_oe_n(card_oe_n), .o_supply_5v_ctrl(sup5), .o_supply_3v_ctrl(sup3),
        .o_resume_request_n(resume_n), .o_csc_irq(csc_irq), .o_irq(irq)
    );

    csc_card_model card_u (
        .i_present(present), .i_sense(sense), .o_card_detect_a_n(det_a_n),
        .o_card_detect_b_n(det_b_n), .o_volt_sense_a(vs_a), .o_volt_sense_b(vs_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic chkb(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask : chkb

    // The slave's wait states are not assumed; a stuck transfer ends the run.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            end_sim();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rdata, {24'h0, exp});
    endtask : rdc

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, mem_req, present} = 5'h0;
        {paddr, pwdata} = 64'h0;
        {we_n, oe_n} = 2'b11;
        sys_addr = 14'h0000;
        sense = 2'b00;
        repeat (20) @(posedge clk);
        chk({29'h0, sup5, sup3, resume_n}, 32'h7);
        rst_n <= 1'b1;
        foreach (wrows[i]) rdc(wrows[i].wid | 8'h15, 8'h00);
        rdc(`CSC_IDX_GLB, 8'h00);
        rdc(`CSC_IDX_SUPPLY_SELECT, 8'h00);
        wr(`CSC_IDX_PWR, 8'h10);
        present <= 1'b1;
        foreach (rows[i]) begin
            sense <= rows[i].code;
            wr(`CSC_IDX_SUPPLY_SELECT, {6'h0, rows[i].code});
            repeat (2) @(posedge clk);
            chk({30'h0, sup5, sup3}, {30'h0, rows[i].sup});
            rdc(`CSC_IDX_VSENSE, {6'h0, rows[i].code});
        end
        // Window address, space select and strobe handling.
        wr(`CSC_IDX_WEN, 8'h01);
        wr(`CSC_IDX_OFFLO, 8'h80);
        wr(`CSC_IDX_OFFHI, 8'h41);
        mem_req <= 1'b1;
        sys_addr <= 14'h0080;
        repeat (3) @(posedge clk);
        chk({18'h0, card_addr}, 32'h0200);
        chkb(card_sel, 1'b1);
        foreach (wrows[i]) begin
            wr(`CSC_IDX_WIDTH, wrows[i].wid);
            wr(`CSC_IDX_DGC, wrows[i].dgc);
            wr(`CSC_IDX_OFFHI, wrows[i].ohi);
            @(posedge clk);
            we_n <= 1'b0;
            oe_n <= 1'b0;
            repeat (2) @(posedge clk);
            chkb(card_we_n, wrows[i].e1);
            chkb(card_oe_n, wrows[i].e1 && !wrows[i].ohi[7]);
            @(posedge clk);
            chkb(card_we_n, wrows[i].e2);
            chkb(card_oe_n, 1'b0);
            chkb(card_attr, wrows[i].ohi[6]);
            {we_n, oe_n} <= 2'b11;
        end
        mem_req <= 1'b0;
        present <= 1'b0;
        repeat (8) @(posedge clk);
        // Soft detect, first while detect interrupts are off.
        wr(`CSC_IDX_DGC, 8'h20);
        rdc(`CSC_IDX_CSC, 8'h00);
        rdc(`CSC_IDX_DGC, 8'h00);
        wr(`CSC_IDX_CSCCFG, 8'h08);
        wr(`CSC_IDX_DGC, 8'h20);
        repeat (3) @(posedge clk);
        chkb(csc_irq, 1'b1);
        rdc(`CSC_IDX_CSC, 8'h08);
        rdc(`CSC_IDX_CSC, 8'h00);
        wr(`CSC_IDX_GLB, 8'h04);
        wr(`CSC_IDX_DGC, 8'h20);
        rdc(`CSC_IDX_CSC, 8'h08);
        rdc(`CSC_IDX_CSC, 8'h08);
        wr(`CSC_IDX_CSC, 8'h08);
        rdc(`CSC_IDX_CSC, 8'h00);
        wr(`CSC_IDX_GLB, 8'h00);
        // Hardware detect with the interrupt masked, then unmasked.
        wr(`CSC_IDX_IST, 8'h03);
        wr(`CSC_IDX_IMSK, 8'h00);
        present <= 1'b1;
        repeat (8) @(posedge clk);
        chkb(csc_irq, 1'b1);
        chkb(irq, 1'b0);
        rdc(`CSC_IDX_IST, 8'h01);
        wr(`CSC_IDX_IMSK, 8'h01);
        repeat (2) @(posedge clk);
        chkb(irq, 1'b1);
        wr(`CSC_IDX_IST, 8'h01);
        repeat (2) @(posedge clk);
        chkb(irq, 1'b0);
        rdc(`CSC_IDX_CSC, 8'h08);
        // Resume signalling on removal, then the host follows up in software.
        wr(`CSC_IDX_DGC, 8'h10);
        present <= 1'b0;
        repeat (8) @(posedge clk);
        chkb(resume_n, 1'b0);
        chkb(csc_irq, 1'b0);
        rdc(`CSC_IDX_CSC, 8'h08);
        repeat (2) @(posedge clk);
        chkb(resume_n, 1'b1);
        wr(`CSC_IDX_DGC, 8'h30);
        repeat (3) @(posedge clk);
        chkb(csc_irq, 1'b1);
        rdc(`CSC_IDX_CSC, 8'h08);
        wr(`CSC_IDX_CSCCFG, 8'h00);
        present <= 1'b1;
        repeat (8) @(posedge clk);
        chkb(resume_n, 1'b1);
        // Removal with configuration reset enabled.
        wr(`CSC_IDX_DGC, 8'h02);
        wr(`CSC_IDX_OFFHI, 8'hc5);
        wr(`CSC_IDX_WEN, 8'h01);
        rdc(`CSC_IDX_OFFHI, 8'hc5);
        present <= 1'b0;
        repeat (8) @(posedge clk);
        rdc(`CSC_IDX_OFFHI, 8'h00);
        rdc(`CSC_IDX_WEN, 8'h00);
        rdc(`CSC_IDX_DGC, 8'h02);
        // An unmapped index answers with an error and zero data.
        apb(1'b0, 8'h3f, 32'h0);
        chkb(rerr, 1'b1);
        chk(rdata, 32'h0);
        end_sim();
    end
endmodule : tb_card_slot_control_regs
`default_nettype wire
